// file: design/acal_pkg.sv
// What this block does
// RL1 - Offset word lives in byte registers 17h (low) and 18h (high), reset zero.
// RL2 - The two offset bytes join into one 16-bit offset word.
// RL3 - The offset word is signed two's complement.
// RL4 - Offset is shifted left so its top bit meets the result's top bit.
// RL5 - Aligned offset is subtracted from each raw result first.
// RL6 - Gain word lives in registers 19h (low) and 1Ah (high), reset 00h, 40h.
// RL7 - The two gain bytes join into one 16-bit gain word.
// RL8 - The gain word is unsigned straight binary.
// RL9 - Scale factor is gain divided by 4000h; reset value gives unity.
// RL10 - The offset-corrected result is multiplied by the scale factor.
// RL11 - Calibrated result clamps to signed 24-bit range instead of wrapping.
package acal_pkg;
  // ****************************************
  // Register map (word addresses, matched directly)
  // ****************************************
  localparam logic [7:0] ACAL_IDX_OFS_LO = 8'h17;
  localparam logic [7:0] ACAL_IDX_OFS_HI = 8'h18;
  localparam logic [7:0] ACAL_IDX_GAIN_LO = 8'h19;
  localparam logic [7:0] ACAL_IDX_GAIN_HI = 8'h1A;
  localparam logic [7:0] ACAL_IDX_STATUS = 8'h1B;
  localparam logic [7:0] ACAL_RST_OFS_LO = 8'h00;
  localparam logic [7:0] ACAL_RST_OFS_HI = 8'h00;
  localparam logic [7:0] ACAL_RST_GAIN_LO = 8'h00;
  localparam logic [7:0] ACAL_RST_GAIN_HI = 8'h40;
  // ****************************************
  // Datapath layout
  // ****************************************
  localparam int ACAL_RES_W = 24;
  localparam int ACAL_CAL_W = 16;
  localparam int ACAL_OFS_SHIFT = ACAL_RES_W - ACAL_CAL_W;
  localparam int ACAL_GAIN_FRAC = 14;
  localparam int ACAL_FIFO_DEPTH = 4;
  localparam logic [31:0] ACAL_UNMAPPED = 32'h0000_0000;
endpackage

// file: design/acal_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module acal_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic in_valid, // Write offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word written
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain side takes word
  output logic [WIDTH-1:0] out_data // Head word, registered
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic ov_q, ov_d;
  logic wr, rd, ld;

  // Pointer, count and head register update
  always_comb begin
    wr = in_valid && (cnt_q != DEPTH_C);
    ld = (cnt_q != '0) && (!ov_q || out_ready);
    rd = ld;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    out_d = out_q;
    ov_d = ov_q && !out_ready;
    if (wr) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
    end
    if (ld) begin
      out_d = mem_q[rp_q];
      ov_d = 1'b1;
      rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  end

  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      ov_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      ov_q <= ov_d;
    end
  end

  assign in_ready = (cnt_q != DEPTH_C);
  assign out_valid = ov_q;
  assign out_data = out_q;
endmodule
`default_nettype wire

// file: design/acal_top.sv
`timescale 1ns/1ps
`default_nettype none
module acal_top import acal_pkg::*; #(
  parameter int RES_W = 24
) (
  input wire logic clk, // Clock, 250 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic [7:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic raw_valid, // Raw result offered
  output logic raw_ready, // Raw result accepted
  input wire logic [RES_W-1:0] raw_data, // Raw signed result
  output logic cal_valid, // Calibrated result valid
  input wire logic cal_ready, // Sink takes result
  output logic [RES_W-1:0] cal_data // Calibrated result
);
  localparam logic signed [RES_W+17:0] MAXV =
    (RES_W+18)'((64'sd1 <<< (RES_W-1)) - 1);
  localparam logic signed [RES_W+17:0] MINV =
    (RES_W+18)'(-(64'sd1 <<< (RES_W-1)));

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ofs_lo_q, ofs_lo_d, ofs_hi_q, ofs_hi_d;
  logic [7:0] gain_lo_q, gain_lo_d, gain_hi_q, gain_hi_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic sat_q, sat_d;
  logic wr_go;
  logic [ACAL_CAL_W-1:0] aux_offset_word, aux_gain_word;

  // Access accepted on the cycle waitrequest is low
  always_comb begin
    wr_go = avs_write && !wait_q;
    wait_d = (avs_read || avs_write) && wait_q ? 1'b0 : 1'b1;
    ofs_lo_d = ofs_lo_q;
    ofs_hi_d = ofs_hi_q;
    gain_lo_d = gain_lo_q;
    gain_hi_d = gain_hi_q;
    rdata_d = rdata_q;
    if (wr_go && avs_byteenable[0]) begin
      unique case (avs_address)
        ACAL_IDX_OFS_LO: ofs_lo_d = avs_writedata[7:0]; // RL1
        ACAL_IDX_OFS_HI: ofs_hi_d = avs_writedata[7:0]; // RL1
        ACAL_IDX_GAIN_LO: gain_lo_d = avs_writedata[7:0]; // RL6
        ACAL_IDX_GAIN_HI: gain_hi_d = avs_writedata[7:0]; // RL6
        default: ;
      endcase
    end
    if (avs_read && wait_q) begin
      unique case (avs_address)
        ACAL_IDX_OFS_LO: rdata_d = {24'h000000, ofs_lo_q};
        ACAL_IDX_OFS_HI: rdata_d = {24'h000000, ofs_hi_q};
        ACAL_IDX_GAIN_LO: rdata_d = {24'h000000, gain_lo_q};
        ACAL_IDX_GAIN_HI: rdata_d = {24'h000000, gain_hi_q};
        ACAL_IDX_STATUS: rdata_d = {30'h0, cal_valid, sat_q};
        default: rdata_d = ACAL_UNMAPPED;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ofs_lo_q <= ACAL_RST_OFS_LO; // RL1
      ofs_hi_q <= ACAL_RST_OFS_HI; // RL1
      gain_lo_q <= ACAL_RST_GAIN_LO; // RL6
      gain_hi_q <= ACAL_RST_GAIN_HI; // RL6
      rdata_q <= 32'h00000000;
      wait_q <= 1'b1;
    end else begin
      ofs_lo_q <= ofs_lo_d;
      ofs_hi_q <= ofs_hi_d;
      gain_lo_q <= gain_lo_d;
      gain_hi_q <= gain_hi_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign aux_offset_word = {ofs_hi_q, ofs_lo_q}; // RL2
  assign aux_gain_word = {gain_hi_q, gain_lo_q}; // RL7
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ****************************************
  // Calibration datapath, two stages
  // ****************************************
  logic s1_v_q, s1_v_d, s2_v_q, s2_v_d;
  logic signed [RES_W+1:0] diff_q, diff_d;
  logic signed [RES_W+17:0] prod;
  logic signed [RES_W+17:0] scaled;
  logic [RES_W-1:0] res_q, res_d;
  logic adv1, adv2, fifo_rdy;
  logic signed [RES_W+1:0] ofs_al;

  // Offset aligned to the top of the result, sign kept
  assign ofs_al = (RES_W+2)'($signed(aux_offset_word)) <<< // RL3
    (RES_W - ACAL_CAL_W); // RL4
  // Gain as unsigned, scaled down by 2^14 so 4000h is unity
  assign prod = diff_q * $signed({1'b0, aux_gain_word}); // RL8 RL10
  assign scaled = prod >>> ACAL_GAIN_FRAC; // RL9

  // Pipeline advance with stall from the FIFO
  always_comb begin
    adv2 = !s2_v_q || fifo_rdy;
    adv1 = !s1_v_q || adv2;
    s1_v_d = adv1 ? raw_valid : s1_v_q;
    diff_d = diff_q;
    if (adv1 && raw_valid) begin
      diff_d = (RES_W+2)'($signed(raw_data)) - ofs_al; // RL5
    end
    s2_v_d = adv2 ? s1_v_q : s2_v_q;
    res_d = res_q;
    sat_d = sat_q;
    if (adv2 && s1_v_q) begin
      if (scaled > MAXV) begin
        res_d = MAXV[RES_W-1:0]; // RL11
        sat_d = 1'b1;
      end else if (scaled < MINV) begin
        res_d = MINV[RES_W-1:0]; // RL11
        sat_d = 1'b1;
      end else begin
        res_d = scaled[RES_W-1:0];
        sat_d = 1'b0;
      end
    end
  end

  // Pipeline registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_v_q <= 1'b0;
      s2_v_q <= 1'b0;
      diff_q <= '0;
      res_q <= '0;
      sat_q <= 1'b0;
    end else begin
      s1_v_q <= s1_v_d;
      s2_v_q <= s2_v_d;
      diff_q <= diff_d;
      res_q <= res_d;
      sat_q <= sat_d;
    end
  end

  assign raw_ready = !s1_v_q || !s2_v_q || fifo_rdy;

  // Output buffer, back-pressure stalls the pipeline
  acal_fifo #(
    .WIDTH(RES_W),
    .DEPTH(ACAL_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(s2_v_q),
    .in_ready(fifo_rdy),
    .in_data(res_q),
    .out_valid(cal_valid),
    .out_ready(cal_ready),
    .out_data(cal_data)
  );
endmodule
`default_nettype wire

// file: testbench/acal_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acal_chk #(
  parameter int RES_W = 24
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic [7:0] avs_address, // Index
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Wdata
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Rdata
  input wire logic avs_waitrequest, // Stall
  input wire logic raw_valid, // Raw valid
  input wire logic raw_ready, // Raw ready
  input wire logic [RES_W-1:0] raw_data, // Raw
  input wire logic cal_valid, // Out valid
  input wire logic cal_ready, // Out ready
  input wire logic [RES_W-1:0] cal_data // Out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Bus timing, read data and stream handshake
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus wait too long");
  property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low twice");
  property p_rd_byte; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("read upper bits set");
  property p_unmapped; avs_read && !avs_waitrequest && (avs_address < 8'h17 ||
    avs_address > 8'h1B) |-> avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_rd_stable; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_hold; cal_valid && !cal_ready |=> cal_valid && $stable(cal_data); endproperty
  a_hold: assert property (p_hold) else $error("result dropped");
  property p_latency; raw_valid && raw_ready && !cal_valid |-> ##[1:4] cal_valid; endproperty
  a_latency: assert property (p_latency) else $error("result late");
  property p_full; !raw_ready |-> cal_valid; endproperty
  a_full: assert property (p_full) else $error("refused while empty");
endmodule
`default_nettype wire

// file: testbench/acal_src.sv
`timescale 1ns/1ps
`default_nettype none
module acal_src (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic raw_ready, // Block takes result
  output logic raw_valid, // Result offered
  output logic [23:0] raw_data // Raw result
);
  logic [23:0] q[$];
  // Queue a conversion result
  task automatic push(input logic [23:0] d);
    q.push_back(d);
  endtask
  // Offer head result until taken, scramble data when idle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      raw_valid <= 1'h0;
      raw_data <= 24'h0;
    end else begin
      if (raw_valid && raw_ready) q.delete(0);
      raw_valid <= q.size() != 0;
      raw_data <= (q.size() != 0) ? q[0] : ~raw_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_aux_adc_offset_gain_calibration.sv
`timescale 1ns/1ps
`default_nettype none
module test_aux_adc_offset_gain_calibration import acal_pkg::*;;
  logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0, cal_ready = 0;
  logic [7:0] avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, raw_valid, raw_ready, cal_valid;
  logic [23:0] raw_data, cal_data, oq[$];
  int errors = 0, checks = 0;
  // Clock
  always #2 clk = ~clk;
  acal_top i_acal_top (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid),
    .raw_ready(raw_ready), .raw_data(raw_data), .cal_valid(cal_valid),
    .cal_ready(cal_ready), .cal_data(cal_data));
  acal_src i_acal_src (.clk(clk), .rstn(rstn), .raw_ready(raw_ready),
    .raw_valid(raw_valid), .raw_data(raw_data));
  // Sink collects accepted results
  always @(posedge clk) if (cal_valid === 1'h1 && cal_ready) oq.push_back(cal_data);
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // Look between edges so the settled registered answer is seen
    do @(negedge clk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    @(posedge clk);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  function automatic logic [23:0] cal(logic [23:0] r, logic [15:0] o, g);
    longint v;
    v = (longint'($signed(r)) - longint'($signed(o)) * 256) * longint'(g);
    v = v >>> 14;
    return (v > 8388607) ? 24'h7FFFFF : (v < -8388608) ? 24'h800000 : v[23:0];
  endfunction
  task automatic setcal(input logic [15:0] o, g);
    bus(1, 8'h17, o[7:0]);
    bus(1, 8'h18, o[15:8]);
    bus(1, 8'h19, g[7:0]);
    bus(1, 8'h1A, g[15:8]);
  endtask
  task automatic wait_out(input int n);
    for (int i = 0; i < 60 && oq.size() < n; i++) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [7:0] rv[4] = '{8'h00, 8'h00, 8'h00, 8'h40};
    for (int i = 0; i < 4; i++) begin
      bus(0, 8'(8'h17 + i), 8'h0);
      chk("reset", rd, {24'h0, rv[i]});
      bus(1, 8'(8'h17 + i), 8'hA5 ^ 8'(i));
      bus(0, 8'(8'h17 + i), 8'h0);
      chk("rw", rd, {24'h0, 8'hA5 ^ 8'(i)});
    end
    bus(1, 8'h30, 8'hFF);
    bus(0, 8'h30, 8'h0);
    chk("unmapped", rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_cal;
    logic [15:0] co[7] = '{16'h0, 16'h0100, 16'hFF00, 16'h0, 16'h0, 16'h0, 16'h7FFF};
    logic [15:0] cg[7] = '{16'h4000, 16'h4000, 16'h4000, 16'h8000, 16'hFFFF, 16'hFFFF, 16'h4000};
    logic [23:0] cr[7] = '{24'h123456, 24'h0, 24'h0, 24'h100000, 24'h7FFFFF, 24'h800000, 24'h800000};
    cal_ready <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      setcal(co[i], cg[i]);
      oq.delete();
      i_acal_src.push(cr[i]);
      wait_out(1);
      chk("cal", {8'h0, oq[0]}, {8'h0, cal(cr[i], co[i], cg[i])});
    end
    bus(0, 8'h1B, 8'h0);
    chk("status", rd, 32'h1);
    $display("t_cal done");
  endtask
  task automatic t_stream;
    setcal(16'h0010, 16'h2000);
    cal_ready <= 1'h0;
    oq.delete();
    for (int i = 0; i < 8; i++) i_acal_src.push({4'(i * 3), 20'h0});
    for (int i = 0; i < 60 && raw_ready !== 1'h0; i++) @(posedge clk);
    chk("full", {31'h0, raw_ready}, 32'h0);
    cal_ready <= 1'h1;
    wait_out(8);
    for (int i = 0; i < 8; i++)
      chk("stream", {8'h0, oq[i]}, {8'h0, cal({4'(i * 3), 20'h0}, 16'h0010, 16'h2000)});
    $display("t_stream done");
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    t_regs;
    t_cal;
    t_stream;
    end_of_test;
  end
  // Watchdog
  initial begin
    #40000;
    errors++;
    end_of_test;
  end
endmodule
bind acal_top acal_chk #(.RES_W(RES_W)) i_acal_chk (.clk(clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_data(raw_data),
  .cal_valid(cal_valid), .cal_ready(cal_ready), .cal_data(cal_data));
`default_nettype wire
